// File: hw/sfpi_pkg.sv
// Purpose: shared constants for the serial flash pin interface
// Assumes: 10 MHz system clock samples the serial clock pins
// Notes: command codes are plain defaults, not fixed by the pins
package sfpi_pkg;
   // frame decoder states
   typedef enum logic [2:0]
   {
      SFPI_IDLE = 3'b000, // deselected, standby
      SFPI_CMD = 3'b001, // shifting the command byte
      SFPI_ADDR = 3'b010, // shifting address bytes
      SFPI_DUMMY = 3'b011, // dummy byte before fast/dual read
      SFPI_READ = 3'b100, // single lane read data
      SFPI_DREAD = 3'b101, // dual lane read data
      SFPI_WDATA = 3'b110, // write data bytes into fifo
      SFPI_SINK = 3'b111 // unknown command, ignore rest of frame
   } sfpi_state_t;
   // command codes (chosen defaults)
   localparam logic [7:0] SFPI_CMD_READ = 8'h03;
   localparam logic [7:0] SFPI_CMD_FREAD = 8'h0B;
   localparam logic [7:0] SFPI_CMD_DREAD = 8'h3B;
   localparam logic [7:0] SFPI_CMD_PROG = 8'h02;
   localparam logic [7:0] SFPI_CMD_ERASE = 8'h20;
   // frame geometry
   localparam logic [4:0] SFPI_ADDR_BITS = 5'h18;
   localparam logic [4:0] SFPI_BYTE_BITS = 5'h08;
   localparam logic [4:0] SFPI_PAIR_COUNT = 5'h04;
   // data fifo
   localparam int SFPI_FIFO_WIDTH = 8;
   localparam int SFPI_FIFO_DEPTH = 8;
   // self-timed busy time, cycles at 10 MHz (100 ns)
   localparam int SFPI_CLK_NS = 100;
   localparam int SFPI_BUSY_US = 2;
   localparam int SFPI_BUSY_CYC = (SFPI_BUSY_US * 1000 + SFPI_CLK_NS - 1) / SFPI_CLK_NS;
   localparam logic [15:0] SFPI_BUSY_CNT = 16'(SFPI_BUSY_CYC);
endpackage

// File: hw/sfpi_sync.sv
// Purpose: two flip-flop synchroniser for asynchronous pin levels
// Assumes: inputs change slowly compared with clk
// Notes: reset value is a parameter so idle-high pins reset high
`timescale 1ns/1ns
module sfpi_sync
#(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // asynchronous in, synchronous out
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta; // first stage, read only by second stage

   // two stage capture
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meta <= INIT;
         sync_out <= INIT;
      end
      else
      begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule

// File: hw/sfpi_fifo.sv
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: single clock domain
// Notes: depth must be a power of two
`timescale 1ns/1ns
module sfpi_fifo
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
)
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data,
   // flush clears both pointers; sfpi_core ties it low
   input wire logic flush
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH]; // storage
   logic [AW:0] wr_ptr; // extra bit tells full from empty
   logic [AW:0] rd_ptr;
   wire do_wr = in_valid && in_ready;
   wire do_rd = out_valid && out_ready;

   assign in_ready = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
   assign out_valid = wr_ptr != rd_ptr;
   assign out_data = mem[rd_ptr[AW-1:0]];

   // pointers
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else if (flush)
      begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end
      else
      begin
         if (do_wr)
            wr_ptr <= wr_ptr + 1'b1;
         if (do_rd)
            rd_ptr <= rd_ptr + 1'b1;
      end
   end

   // storage has no reset
   always_ff @(posedge clk)
   begin
      if (do_wr)
         mem[wr_ptr[AW-1:0]] <= in_data;
   end
endmodule

// File: hw/sfpi_core.sv
// Purpose: pin-side frame logic of a small serial flash
// Assumes: clk at 10 MHz oversamples the serial clock (800 ns period)
// Notes: read data comes from the user side, write data goes to fifo
`timescale 1ns/1ns

module sfpi_core
import sfpi_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // serial pins
   input wire logic cs_b,
   input wire logic sck,
   input wire logic si_in,
   output logic si_out,
   output logic si_oe,
   input wire logic so_in,
   output logic so_out,
   output logic so_oe,
   input wire logic wp_b,
   // read data from the array side
   input wire logic [7:0] rd_data,
   output logic rd_req,
   // program data and address toward the array side
   output logic wr_valid,
   input wire logic wr_ready,
   output logic [7:0] wr_data,
   output logic [23:0] addr,
   // status
   output logic busy,
   output logic standby,
   output logic hw_lock,
   output logic frame_active
);
   // synchronised pins; cs and wp idle high, sck idles low (mode 0)
   // each pin's reset value equals its idle level, so that letting go
   // of reset shows no false edge on any of them
   logic cs_s;
   logic sck_s;
   logic si_s;
   logic wp_s;
   logic sck_d; // previous sampled clock
   logic cs_d; // previous sampled chip select
   sfpi_sync #(.WIDTH(4), .INIT(4'h9)) u_sync
   (
      .clk(clk),
      .rst_b(rst_b),
      .async_in({cs_b, sck, si_in, wp_b}),
      .sync_out({cs_s, sck_s, si_s, wp_s})
   );

   // edge decode; sck edges only count inside a frame, so that a host
   // toggling the clock while deselected shifts nothing in or out
   // sck must stay at or below clk/8 for this sampling to see each level
   wire cs_fall = cs_d && !cs_s;
   wire cs_rise = !cs_d && cs_s;
   wire sck_rise = !sck_d && sck_s && !cs_s;
   wire sck_fall = sck_d && !sck_s && !cs_s;

   // frame state
   sfpi_state_t state;
   sfpi_state_t next_state;
   logic [7:0] shift_in; // incoming bits
   logic [4:0] bit_cnt; // bits seen in current field
   logic [7:0] cmd; // captured command
   logic [7:0] shift_out; // outgoing byte
   logic [2:0] out_cnt; // output steps done in byte
   logic [15:0] busy_cnt; // self-timed countdown
   logic out_started; // first byte loaded

   // fifo between pins and array side
   logic fifo_in_valid;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic fifo_out_ready; // output register can take a byte
   logic [7:0] fifo_out_data;
   wire [7:0] next_shift_in = {shift_in[6:0], si_s};

   // true when a full byte completes on this rising edge
   function automatic logic byte_done(input logic [4:0] cnt);
      byte_done = cnt[2:0] == 3'h7;
   endfunction

   wire byte_end = sck_rise && byte_done(bit_cnt);
   wire addr_end = sck_rise && (bit_cnt == SFPI_ADDR_BITS - 5'h01);
   wire is_read = (state == SFPI_READ) || (state == SFPI_DREAD);
   wire dual = state == SFPI_DREAD;
   wire [2:0] out_last = dual ? 3'(SFPI_PAIR_COUNT - 5'h01) : 3'(SFPI_BYTE_BITS - 5'h01);
   // a fresh byte is fetched on the first fall and after the last step
   // of each byte; the address moves on at that same edge, so the array
   // side always presents the byte that the next load will take
   wire read_load = is_read && sck_fall && (!out_started || out_cnt == out_last);

   // next-state decode
   always_comb
   begin
      next_state = state;
      case (state)
         SFPI_IDLE:
            if (cs_fall)
               next_state = SFPI_CMD;
         SFPI_CMD:
            if (byte_end)
            begin
               if (busy)
                  next_state = SFPI_SINK; // array busy, no new command
               else if (next_shift_in == SFPI_CMD_READ || next_shift_in == SFPI_CMD_FREAD
                        || next_shift_in == SFPI_CMD_DREAD || next_shift_in == SFPI_CMD_PROG
                        || next_shift_in == SFPI_CMD_ERASE)
                  next_state = SFPI_ADDR;
               else
                  next_state = SFPI_SINK;
            end
         SFPI_ADDR:
            if (addr_end)
            begin
               case (cmd)
                  SFPI_CMD_READ: next_state = SFPI_READ;
                  SFPI_CMD_PROG: next_state = SFPI_WDATA;
                  SFPI_CMD_ERASE: next_state = SFPI_SINK;
                  default: next_state = SFPI_DUMMY;
               endcase
            end
         SFPI_DUMMY:
            if (byte_end)
               next_state = (cmd == SFPI_CMD_DREAD) ? SFPI_DREAD : SFPI_READ;
         default:
            next_state = state;
      endcase
      if (cs_rise || cs_s)
         next_state = SFPI_IDLE;
   end

   // state, bit counter and input shifter
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state <= SFPI_IDLE;
         bit_cnt <= '0;
         shift_in <= '0;
         cmd <= '0;
         addr <= '0;
         sck_d <= 1'b0;
         cs_d <= 1'b1;
      end
      else
      begin
         state <= next_state;
         sck_d <= sck_s;
         cs_d <= cs_s;
         if (next_state != state)
            bit_cnt <= '0;
         else if (sck_rise)
            bit_cnt <= bit_cnt + 5'h01;
         if (sck_rise)
            shift_in <= next_shift_in;
         // a command refused while busy is not kept, so the closing
         // edge of its frame cannot start a cycle on its behalf
         if (state == SFPI_CMD && byte_end)
            cmd <= busy ? 8'h00 : next_shift_in;
         // address shifts in msb first, then counts up per fetched byte
         if (state == SFPI_ADDR && sck_rise)
            addr <= {addr[22:0], si_s};
         else if (read_load)
            addr <= addr + 24'h00_0001; // step past the byte just loaded
      end
   end

   // fifo fill: one write byte per completed byte; a locked device
   // takes no program data at all, and a full fifo drops the byte
   // because the serial side has no way to stall the host
   assign fifo_in_valid = (state == SFPI_WDATA) && byte_end && !hw_lock
                          && fifo_in_ready;
   sfpi_fifo #(.WIDTH(SFPI_FIFO_WIDTH), .DEPTH(SFPI_FIFO_DEPTH)) u_fifo
   (
      .clk(clk),
      .rst_b(rst_b),
      .in_valid(fifo_in_valid),
      .in_ready(fifo_in_ready),
      .in_data(next_shift_in),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out_data),
      .flush(1'b0)
   );
   // output register: wr_valid and wr_data come straight from flops;
   // it adds one place, so fifo and register hold nine bytes together
   // and the host must pace program data to the array's drain rate
   assign fifo_out_ready = !wr_valid || wr_ready;
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         wr_valid <= 1'b0;
         wr_data <= '0;
      end
      else if (fifo_out_ready)
      begin
         // refill when empty or when the array takes the held byte
         wr_valid <= fifo_out_valid;
         wr_data <= fifo_out_data;
      end
   end

   // output shifter; launch on falling edges only
   // the pins are released at once when the frame ends or leaves a read
   // state, whatever step the shifter had reached
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         shift_out <= '0;
         out_cnt <= '0;
         out_started <= 1'b0;
         so_out <= 1'b0;
         si_out <= 1'b0;
         so_oe <= 1'b0;
         si_oe <= 1'b0;
         rd_req <= 1'b0;
      end
      else if (!is_read || cs_s)
      begin
         out_started <= 1'b0;
         out_cnt <= '0;
         so_oe <= 1'b0;
         si_oe <= 1'b0;
         rd_req <= 1'b0;
      end
      else
      begin
         rd_req <= 1'b0;
         if (sck_fall)
         begin
            so_oe <= 1'b1;
            si_oe <= dual;
            if (!out_started || out_cnt == out_last)
            begin
               // load a fresh byte and launch its first bit or pair
               out_started <= 1'b1;
               out_cnt <= '0;
               rd_req <= 1'b1;
               so_out <= rd_data[7];
               si_out <= rd_data[6];
               shift_out <= dual ? {rd_data[5:0], 2'b00} : {rd_data[6:0], 1'b0};
            end
            else
            begin
               out_cnt <= out_cnt + 3'h1;
               so_out <= shift_out[7];
               si_out <= shift_out[6];
               shift_out <= dual ? {shift_out[5:0], 2'b00} : {shift_out[6:0], 1'b0};
            end
         end
      end
   end

   // a program or erase frame that closes cleanly while hw_lock is low starts the cycle;
   // a frame cut short in the command or address field starts nothing
   wire cycle_cmd = (cmd == SFPI_CMD_PROG) || (cmd == SFPI_CMD_ERASE);
   wire cycle_start = cs_rise && !busy && !hw_lock && cycle_cmd
                      && ((state == SFPI_WDATA) || (state == SFPI_SINK));

   // self-timed cycle: starts on the closing edge, survives deselect
   // the start takes priority over the countdown in the same cycle
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         busy_cnt <= '0;
      else if (cycle_start)
         busy_cnt <= SFPI_BUSY_CNT;
      else if (busy_cnt != '0)
         busy_cnt <= busy_cnt - 16'h0001;
   end

   // status flops; all are registered so that every status pin
   // comes straight from a flop, at one clk of extra latency
   // hw_lock follows the pin level; the pull-up leaves it released
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         busy <= 1'b0;
         standby <= 1'b1;
         hw_lock <= 1'b0;
         frame_active <= 1'b0;
      end
      else
      begin
         // busy covers the start cycle and the countdown down to one, so
         // it stands for exactly the busy count of cycles
         busy <= cycle_start || (busy_cnt > 16'h0001);
         // standby waits for the end of any cycle, the starting one too
         standby <= cs_s && !cycle_start && (busy_cnt <= 16'h0001);
         hw_lock <= !wp_s;
         frame_active <= !cs_s;
      end
   end
endmodule

// File: tb/sfpi_core_asserts.sv
// Purpose: pin-level checks for sfpi_core
// Assumes: sck period of at least 8 clk
// Notes: bound into every sfpi_core
`timescale 1ns/1ns
module sfpi_core_asserts
import sfpi_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // pins
   input wire logic cs_b,
   input wire logic sck,
   input wire logic wp_b,
   input wire logic so_out,
   input wire logic so_oe,
   input wire logic si_oe,
   // status
   input wire logic busy,
   input wire logic standby,
   input wire logic hw_lock,
   input wire logic frame_active
);
   logic [15:0] busy_len; // length of the running busy stretch
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // counter, because a repetition cannot reach the busy time
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         busy_len <= 16'h0000;
      else
         busy_len <= busy ? busy_len + 16'h0001 : 16'h0000;
   end
   sequence s_desel; cs_b[*6]; endsequence
   property p_start; $fell(cs_b) |-> ##[1:3] frame_active; endproperty
   a_start: assert property (p_start) else $error("frame not opened");
   property p_end; $rose(cs_b) |-> ##[1:3] !frame_active; endproperty
   a_end: assert property (p_end) else $error("frame not closed");
   property p_stby; (cs_b && !busy)[*4] |-> standby; endproperty
   a_stby: assert property (p_stby) else $error("no standby");
   property p_busy; busy ##1 busy |-> !standby; endproperty
   a_busy: assert property (p_busy) else $error("standby while busy");
   property p_blen; $fell(busy) |-> busy_len == SFPI_BUSY_CNT; endproperty
   a_blen: assert property (p_blen) else $error("busy time wrong");
   property p_rel; s_desel |-> !so_oe && !si_oe; endproperty
   a_rel: assert property (p_rel) else $error("pin driven deselected");
   property p_ign; cs_b[*4] |-> !frame_active; endproperty
   a_ign: assert property (p_ign) else $error("input taken deselected");
   property p_fall; so_oe && $changed(so_out) |-> !$past(sck, 3); endproperty
   a_fall: assert property (p_fall) else $error("launch not on fall");
   property p_dual; si_oe |-> so_oe; endproperty
   a_dual: assert property (p_dual) else $error("lane one idle");
   property p_lock; (!wp_b)[*4] |-> hw_lock; endproperty
   a_lock: assert property (p_lock) else $error("lock missing");
   property p_free; wp_b[*4] |-> !hw_lock; endproperty
   a_free: assert property (p_free) else $error("lock stuck");
endmodule
bind sfpi_core sfpi_core_asserts chk (.clk, .rst_b, .cs_b, .sck, .wp_b, .so_out, .so_oe,
   .si_oe, .busy, .standby, .hw_lock, .frame_active);

// File: tb/sfpi_host.sv
// Purpose: spi host model facing the flash pins
// Assumes: mode 0, sck 4 clk low then 4 clk high
// Notes: undriven lines wander instead of holding
`timescale 1ns/1ns
module sfpi_host
(
   // system clock
   input wire logic clk,
   // host pins
   output logic cs_b,
   output logic sck,
   // resolved lane lines
   output logic si_line,
   output logic so_line,
   // device drive
   input wire logic si_out,
   input wire logic si_oe,
   input wire logic so_out,
   input wire logic so_oe
);
   logic h_si = 1'b0; // host drive of lane zero
   logic h_oe = 1'b0; // host drives lane zero
   logic tog = 1'b0; // pattern on a released line
   always @(posedge clk) tog <= ~tog;
   assign si_line = si_oe ? si_out : (h_oe ? h_si : tog);
   assign so_line = so_oe ? so_out : tog;
   initial
   begin
      cs_b = 1'b1;
      sck = 1'b0;
   end
   // open or close a frame with sck parked low
   task automatic frame(input logic sel);
      repeat (4) @(negedge clk);
      h_oe = sel;
      cs_b = ~sel;
   endtask
   // one serial clock; read bits taken late, just before the next fall
   task automatic bit_cyc(input logic d, output logic [1:0] b);
      h_si = d; // stable through the rise
      repeat (4) @(negedge clk);
      sck = 1'b1;
      repeat (4) @(negedge clk);
      b = {so_line, si_line};
      sck = 1'b0;
   endtask
   // one byte, msb first; dual mode releases lane zero
   task automatic xfer(input logic [7:0] d, input logic dual, output logic [7:0] q);
      logic [1:0] b;
      q = 8'h00;
      h_oe = !dual;
      for (int i = 0; i < (dual ? 4 : 8); i++)
      begin
         bit_cyc(d[7 - i], b);
         q = dual ? {q[5:0], b} : {q[6:0], b[1]};
      end
   endtask
endmodule

// File: tb/sfpi_core_tb.sv
// Purpose: self-checking bench for sfpi_core
// Assumes: array byte is the address low byte xor a5
// Notes: fifo is stalled during program to fill it
`timescale 1ns/1ns
module sfpi_core_tb
import sfpi_pkg::*;
;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic wp_b = 1'b1; // pull-up stand-in
   logic wr_ready = 1'b0;
   logic cs_b, sck, si_line, so_line, si_out, si_oe, so_out, so_oe;
   logic rd_req, wr_valid, busy, standby, hw_lock, frame_active;
   logic [7:0] wr_data, q;
   logic [23:0] addr;
   logic [7:0] got_q[$]; // program bytes drained
   int fails = 0;
   int cmp_count = 0;
   int rd_pulses = 0; // array fetches seen on rd_req
   wire logic [7:0] rd_data = addr[7:0] ^ 8'hA5;
   sfpi_core dut (.clk, .rst_b, .cs_b, .sck, .si_in(si_line), .si_out, .si_oe,
      .so_in(so_line), .so_out, .so_oe, .wp_b, .rd_data, .rd_req, .wr_valid,
      .wr_ready, .wr_data, .addr, .busy, .standby, .hw_lock, .frame_active);
   sfpi_host host (.clk, .cs_b, .sck, .si_line, .so_line, .si_out, .si_oe,
      .so_out, .so_oe);
   initial
   begin
      forever #50 clk = ~clk;
   end
   always @(posedge clk) if (wr_valid && wr_ready) got_q.push_back(wr_data);
   always @(posedge clk) if (rd_req) rd_pulses++;
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_byte({7'h00, got}, {7'h00, exp});
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task automatic hdr(input logic [7:0] cmd, input logic [23:0] a);
      host.frame(1'b1);
      host.xfer(cmd, 1'b0, q);
      for (int i = 2; i >= 0; i--)
         host.xfer(a[8*i +: 8], 1'b0, q);
   endtask
   task automatic t_reset;
      chk_bit(standby, 1'b1);
      chk_bit(so_oe, 1'b0);
   endtask
   // two bytes across a low address byte wrap
   task automatic t_read(input logic [7:0] cmd, input logic dual);
      int base;
      base = rd_pulses;
      hdr(cmd, 24'h00_10FF);
      if (cmd != SFPI_CMD_READ)
         host.xfer(8'h00, 1'b0, q);
      for (int i = 0; i < 2; i++)
      begin
         host.xfer(8'hFF, dual, q);
         chk_byte(q, 8'(8'hFF + i) ^ 8'hA5);
      end
      host.frame(1'b0);
      repeat (6) @(negedge clk);
      chk_bit(so_oe, 1'b0);
      chk_bit(si_oe, 1'b0);
      // two bytes read plus the one fetched on the last fall
      chk_byte(8'(rd_pulses - base), 8'h03);
      chk_byte(addr[7:0], 8'h02);
   endtask
   // ten bytes into a stalled fifo of eight plus its output register
   task automatic t_prog;
      hdr(SFPI_CMD_PROG, 24'h00_0200);
      for (int i = 0; i < 10; i++)
         host.xfer(8'(8'h30 + i), 1'b0, q);
      host.frame(1'b0);
      repeat (6) @(negedge clk);
      chk_bit(busy, 1'b1);
      chk_bit(standby, 1'b0);
      wr_ready = 1'b1;
      repeat (40) @(negedge clk);
      chk_byte(8'(got_q.size()), 8'h09);
      for (int i = 0; i < 9; i++)
         chk_byte(got_q[i], 8'(8'h30 + i));
      chk_bit(standby, 1'b1);
   endtask
   task automatic t_erase;
      hdr(SFPI_CMD_ERASE, 24'h00_1000);
      host.frame(1'b0);
      repeat (6) @(negedge clk);
      chk_bit(busy, 1'b1);
      repeat (30) @(negedge clk);
      chk_bit(standby, 1'b1);
   endtask
   task automatic t_lock;
      wp_b = 1'b0;
      repeat (5) @(negedge clk);
      chk_bit(hw_lock, 1'b1);
      got_q.delete();
      hdr(SFPI_CMD_PROG, 24'h00_0300);
      host.xfer(8'h5A, 1'b0, q);
      host.frame(1'b0);
      repeat (10) @(negedge clk);
      chk_byte(8'(got_q.size()), 8'h00);
      chk_bit(busy, 1'b0);
      wp_b = 1'b1;
      repeat (5) @(negedge clk);
      chk_bit(hw_lock, 1'b0);
   endtask
   initial
   begin
      #1_000_000;
      fails++;
      tally_and_finish;
   end
   initial
   begin
      repeat (8) @(negedge clk);
      rst_b = 1'b1;
      repeat (4) @(negedge clk);
      t_reset;
      t_read(SFPI_CMD_READ, 1'b0);
      t_read(SFPI_CMD_FREAD, 1'b0);
      t_read(SFPI_CMD_DREAD, 1'b1);
      t_prog;
      t_erase;
      t_lock;
      tally_and_finish;
   end
endmodule
